// [inc/ffd_pkg.sv]
package ffd_pkg;

  // ----------------------------------------------------------------
  // Function field codes
  // ----------------------------------------------------------------
  localparam logic [4:0] FC_DIVIDE = 5'h04;
  localparam logic [4:0] FC_DECREMENT = 5'h06;
  localparam logic [4:0] FC_ADD_KEEP_OVF = 5'h0A;
  localparam logic [4:0] FC_AND = 5'h0C;
  localparam logic [4:0] FC_COND_JUMP = 5'h14;
  localparam logic [4:0] FC_ROTATE = 5'h17;
  localparam logic [4:0] FC_ARITH_SHIFT = 5'h18;
  localparam logic [4:0] FC_COND_JUMP_ALT = 5'h19;
  localparam logic [4:0] FC_CLEAR_FLAG = 5'h1B;
  localparam logic [4:0] FC_SET_OVF = 5'h1D;

  // ----------------------------------------------------------------
  // Special field codes (encodings live in another decoder)
  // ----------------------------------------------------------------
  localparam logic [4:0] SP_SHIFT_LEFT_ONE = 5'h01;
  localparam logic [4:0] SP_SHIFT_RIGHT_ONE = 5'h02;
  localparam logic [4:0] SP_SKIP_GROUP_TWO = 5'h03;

  // ----------------------------------------------------------------
  // Function generator control, order: mode, carry, sel0..sel3
  // ----------------------------------------------------------------
  typedef struct packed {
    logic logic_mode_select;
    logic carry_control;
    logic func_select_0;
    logic func_select_1;
    logic func_select_2;
    logic func_select_3;
  } ffd_alu_ctrl_t;

  localparam ffd_alu_ctrl_t FG_ADD = 6'h19;
  localparam ffd_alu_ctrl_t FG_AND = 6'h3D;
  localparam ffd_alu_ctrl_t FG_INC = 6'h09;
  localparam ffd_alu_ctrl_t FG_IOR = 6'h37;
  localparam ffd_alu_ctrl_t FG_NOR = 6'h38;
  localparam ffd_alu_ctrl_t FG_SUB_TWOS = 6'h06;
  localparam ffd_alu_ctrl_t FG_SUB_ONES = 6'h16;
  localparam ffd_alu_ctrl_t FG_XOR = 6'h36;
  localparam ffd_alu_ctrl_t FG_PASS_R = 6'h00;

  // ----------------------------------------------------------------
  // Control-store sequencing strobes
  // ----------------------------------------------------------------
  typedef struct packed {
    logic jump_field_flag;
    logic skip_field_decode_enable;
    logic special_field_decode_enable;
    logic pc_read_low;
    logic pc_read_bit_nine;
    logic pc_read_high;
    logic rom_jump;
  } ffd_seq_t;

  // Decode enables and counter reads on, no jump flag, no control-store jump
  localparam ffd_seq_t SEQ_IDLE = 7'h3E;

  // Reset values
  localparam logic [15:0] WORD_RST = 16'h0000;
  localparam logic [7:0] TARGET_RST = 8'h00;

endpackage

// [src/ffd_decoder.sv]
`timescale 1ns/10ps
// Overview of operation
// RULE1 - Code 01010 adds R and S onto T and raises overflow enable
// RULE2 - That add also enables extend for memory-reference or group-two skip
// RULE3 - Code 01100 ANDs R and S, no other control signals
// RULE4 - Code 11000 shifts 32 bits arithmetically; right: B via shifter
// RULE5 - Left shift uses F through shifter, Q internal; result stored in B/F
// RULE6 - Right shift copies sign to bit 15, ALU bit 0 to A15, drops A0
// RULE7 - Left shift keeps sign, overflow on bit 14/15 mismatch, Q15 in, Q0=0
// RULE8 - Arithmetic shift also selects inclusive-OR
// RULE9 - Code 11011 clears CPU flag and selects inclusive-OR
// RULE10 - Codes 10100/11001 jump only on halt or interrupt, inclusive-OR
// RULE11 - Jump blocks skip/special decode; their bits are the target
// RULE12 - Conditional jump disables program-counter read strobes
// RULE13 - Code 11101 sets overflow and selects inclusive-OR
// RULE14 - Code 10111 rotates 32 bits; right: A0 into bit 15, ALU_LOW_BIT into A15
// RULE15 - Left rotate: F through shifter, ALU_SIGN_BIT into Q0, Q carry into ALU_LOW_BIT
// RULE16 - Code 00110 adds ones'-complement of S to R, a decrement
// RULE17 - Function generator patterns are driven as the fixed table gives
// RULE18 - Code 00100 performs one divide step; sixteen make a full divide
// RULE19 - Divide step takes two cycles: freeze and test, then store
// RULE20 - Non-negative difference: F=2*diff+Q15, Q=2Q+1; else F=2F+Q15, Q=2Q
// RULE21 - After sixteen steps Q holds quotient and F remainder
// RULE22 - Microprogram must ensure positive operands and reset step counter
// RULE23 - Divide word selects F, scratch pad two, store F, left, count skip
module ffd_decoder #(
  parameter bit LATE_BUILD = 1'b1
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // Microinstruction register fields
  input wire logic [4:0] func_code,
  input wire logic [4:0] special_code,
  input wire logic [7:0] jump_bits,
  // Processor state
  input wire logic user_mem_ref,
  input wire logic halt_or_irq,
  input wire logic ovf_clear,
  input wire logic flag_set,
  // Data from the arithmetic section
  input wire logic [15:0] r_bus,
  input wire logic [15:0] s_bus,
  input wire logic [15:0] a_reg,
  input wire logic [15:0] q_reg,
  // Function generator control, T-bus word and store strobe
  output ffd_pkg::ffd_alu_ctrl_t alu_ctrl_q,
  output logic [15:0] t_bus_q,
  output logic t_store_q,
  // Internal shift registers
  output logic a_load_q,
  output logic [15:0] a_next_q,
  output logic q_load_q,
  output logic [15:0] q_next_q,
  // Flags and enables
  output logic overflow_enable_q,
  output logic extend_enable_q,
  output logic overflow_flipflop_q,
  output logic cpu_flag_q,
  output logic freeze_q,
  // Control-store sequencing
  output ffd_pkg::ffd_seq_t seq_q,
  output logic [7:0] jump_target_q
);

  typedef enum logic {FFD_DIV_TEST, FFD_DIV_STORE} ffd_div_state_t;
  ffd_div_state_t div_state_q;
  ffd_pkg::ffd_alu_ctrl_t alu_ctrl_d;
  logic [16:0] alu_sum;
  logic [15:0] alu_word;
  logic [15:0] t_bus_d;
  logic [15:0] a_next_d;
  logic [15:0] q_next_d;
  logic a_load_d;
  logic q_load_d;
  logic t_store_d;
  logic ovf_set_d;
  logic is_div;
  logic is_conditional_rom_jump;
  logic left_one;
  logic right_one;
  logic [16:0] div_diff;
  logic div_ok;

  // ----------------------------------------------------------------
  // Decode helpers
  // ----------------------------------------------------------------
  function automatic logic is_cond_jump(input logic [4:0] code);
    is_cond_jump = (code == ffd_pkg::FC_COND_JUMP) ||
                   (LATE_BUILD && code == ffd_pkg::FC_COND_JUMP_ALT);
  endfunction

  // Function generator behaviour for a control pattern
  function automatic logic [16:0] fgen(input ffd_pkg::ffd_alu_ctrl_t c,
                                       input logic [15:0] r,
                                       input logic [15:0] s);
    case (c)
      ffd_pkg::FG_ADD: fgen = {1'b0, r} + {1'b0, s};
      ffd_pkg::FG_AND: fgen = {1'b0, r & s};
      ffd_pkg::FG_INC: fgen = {1'b0, r} + {1'b0, s} + 17'h00001;
      ffd_pkg::FG_IOR: fgen = {1'b0, r | s};
      ffd_pkg::FG_NOR: fgen = {1'b0, ~(r | s)};
      ffd_pkg::FG_SUB_TWOS: fgen = {1'b0, r} + {1'b0, ~s} + 17'h00001;
      ffd_pkg::FG_SUB_ONES: fgen = {1'b0, r} + {1'b0, ~s};
      ffd_pkg::FG_XOR: fgen = {1'b0, r ^ s};
      default: fgen = {1'b0, r};
    endcase
  endfunction

  assign is_div = (func_code == ffd_pkg::FC_DIVIDE);
  assign is_conditional_rom_jump = is_cond_jump(func_code);
  assign left_one = (special_code == ffd_pkg::SP_SHIFT_LEFT_ONE);
  assign right_one = (special_code == ffd_pkg::SP_SHIFT_RIGHT_ONE);
  // Divide test: R minus S, bit 16 set means no borrow
  assign div_diff = {1'b0, r_bus} + {1'b0, ~s_bus} + 17'h00001;
  assign div_ok = div_diff[16];

  // ----------------------------------------------------------------
  // Function generator pattern select
  // ----------------------------------------------------------------
  always_comb begin
    case (func_code)
      ffd_pkg::FC_ADD_KEEP_OVF: alu_ctrl_d = ffd_pkg::FG_ADD; // [RULE1]
      ffd_pkg::FC_AND: alu_ctrl_d = ffd_pkg::FG_AND; // [RULE3]
      ffd_pkg::FC_DECREMENT: alu_ctrl_d = ffd_pkg::FG_SUB_ONES; // [RULE16]
      ffd_pkg::FC_DIVIDE: alu_ctrl_d = ffd_pkg::FG_SUB_TWOS; // [RULE18]
      ffd_pkg::FC_ARITH_SHIFT,
      ffd_pkg::FC_ROTATE,
      ffd_pkg::FC_CLEAR_FLAG,
      ffd_pkg::FC_SET_OVF: alu_ctrl_d = ffd_pkg::FG_IOR; // [RULE8] [RULE9]
      // Conditional jump codes select inclusive-OR; codes owned by other decoders pass R unchanged
      default: alu_ctrl_d = is_conditional_rom_jump ? ffd_pkg::FG_IOR :
                            ffd_pkg::FG_PASS_R; // [RULE10]
    endcase
  end
  assign alu_sum = fgen(alu_ctrl_d, r_bus, s_bus); // [RULE17]
  assign alu_word = alu_sum[15:0];

  // ----------------------------------------------------------------
  // Shifter, internal A/Q shifts and divide step data
  // ----------------------------------------------------------------
  always_comb begin
    t_bus_d = alu_word;
    a_next_d = a_reg;
    q_next_d = q_reg;
    a_load_d = 1'b0;
    q_load_d = 1'b0;
    t_store_d = 1'b1;
    ovf_set_d = 1'b0;
    case (func_code)
      ffd_pkg::FC_ADD_KEEP_OVF: ovf_set_d = (r_bus[15] == s_bus[15]) &&
        (alu_word[15] != r_bus[15]); // Signed overflow [RULE1]
      ffd_pkg::FC_ARITH_SHIFT: begin
        if (right_one) begin
          t_bus_d = {alu_word[15], alu_word[15:1]}; // [RULE4] [RULE6]
          a_next_d = {alu_word[0], a_reg[15:1]}; // [RULE6]
          a_load_d = 1'b1;
        end else if (left_one) begin
          t_bus_d = {alu_word[15], alu_word[13:0], q_reg[15]}; // [RULE7]
          q_next_d = {q_reg[14:0], 1'b0}; // [RULE5] [RULE7]
          q_load_d = 1'b1;
          ovf_set_d = alu_word[14] ^ alu_word[15]; // [RULE7]
        end
      end
      ffd_pkg::FC_ROTATE: begin
        if (right_one) begin
          t_bus_d = {a_reg[0], alu_word[15:1]}; // [RULE14]
          a_next_d = {alu_word[0], a_reg[15:1]}; // [RULE14]
          a_load_d = 1'b1;
        end else if (left_one) begin
          t_bus_d = {alu_word[14:0], q_reg[15]}; // [RULE15]
          q_next_d = {q_reg[14:0], alu_word[15]}; // [RULE15]
          q_load_d = 1'b1;
        end
      end
      ffd_pkg::FC_DIVIDE: begin
        // First pass only tests; second pass stores F and Q
        t_store_d = (div_state_q == FFD_DIV_STORE); // [RULE19]
        q_load_d = (div_state_q == FFD_DIV_STORE); // [RULE19]
        if (div_ok) begin
          t_bus_d = {div_diff[14:0], q_reg[15]}; // [RULE20]
          q_next_d = {q_reg[14:0], 1'b1}; // [RULE20]
        end else begin
          t_bus_d = {r_bus[14:0], q_reg[15]}; // [RULE20] [RULE21]
          q_next_d = {q_reg[14:0], 1'b0}; // [RULE20]
        end
      end
      default: t_bus_d = alu_word; // [RULE3] [RULE16]
    endcase
  end

  // ----------------------------------------------------------------
  // Divide step sequencer
  // ----------------------------------------------------------------
  // Microinstruction register holds the same word during the freeze
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      div_state_q <= FFD_DIV_TEST;
      freeze_q <= 1'b0;
    end else begin
      freeze_q <= is_div && (div_state_q == FFD_DIV_TEST); // [RULE19]
      case (div_state_q)
        FFD_DIV_TEST: begin
          if (is_div) begin
            div_state_q <= FFD_DIV_STORE; // [RULE19]
          end
        end
        FFD_DIV_STORE: div_state_q <= FFD_DIV_TEST; // [RULE19]
        default: div_state_q <= FFD_DIV_TEST;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Registered datapath outputs
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      alu_ctrl_q <= ffd_pkg::FG_PASS_R;
      t_bus_q <= ffd_pkg::WORD_RST;
      t_store_q <= 1'b0;
      a_load_q <= 1'b0;
      a_next_q <= ffd_pkg::WORD_RST;
      q_load_q <= 1'b0;
      q_next_q <= ffd_pkg::WORD_RST;
    end else begin
      alu_ctrl_q <= alu_ctrl_d; // [RULE17]
      t_bus_q <= t_bus_d;
      t_store_q <= t_store_d;
      a_load_q <= a_load_d;
      a_next_q <= a_next_d;
      q_load_q <= q_load_d;
      q_next_q <= q_next_d;
    end
  end

  // Overflow and extend enables for the saved-overflow add
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      overflow_enable_q <= 1'b0;
      extend_enable_q <= 1'b0;
    end else begin
      overflow_enable_q <= (func_code == ffd_pkg::FC_ADD_KEEP_OVF); // [RULE1]
      extend_enable_q <= (func_code == ffd_pkg::FC_ADD_KEEP_OVF) &&
        (user_mem_ref ||
         special_code == ffd_pkg::SP_SKIP_GROUP_TWO); // [RULE2]
    end
  end

  // ----------------------------------------------------------------
  // Overflow and CPU flag flip-flops
  // ----------------------------------------------------------------
  // A set arriving with an outside clear wins, so no event is lost
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      overflow_flipflop_q <= 1'b0;
    end else if (func_code == ffd_pkg::FC_SET_OVF || ovf_set_d) begin
      overflow_flipflop_q <= 1'b1; // [RULE13] [RULE7]
    end else if (ovf_clear) begin
      overflow_flipflop_q <= 1'b0;
    end
  end

  // Outside set wins over the clear code for the same reason
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      cpu_flag_q <= 1'b0;
    end else if (flag_set) begin
      cpu_flag_q <= 1'b1;
    end else if (func_code == ffd_pkg::FC_CLEAR_FLAG) begin
      cpu_flag_q <= 1'b0; // [RULE9]
    end
  end

  // ----------------------------------------------------------------
  // Conditional control-store jump
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      seq_q <= ffd_pkg::SEQ_IDLE;
      jump_target_q <= ffd_pkg::TARGET_RST;
    end else begin
      seq_q.jump_field_flag <= is_conditional_rom_jump;
      seq_q.skip_field_decode_enable <= !is_conditional_rom_jump; // [RULE11]
      seq_q.special_field_decode_enable <= !is_conditional_rom_jump; // [RULE11]
      seq_q.pc_read_low <= !is_conditional_rom_jump; // [RULE12]
      seq_q.pc_read_bit_nine <= !is_conditional_rom_jump; // [RULE12]
      seq_q.pc_read_high <= !is_conditional_rom_jump; // [RULE12]
      seq_q.rom_jump <= is_conditional_rom_jump && halt_or_irq; // [RULE10]
      jump_target_q <= jump_bits; // [RULE11]
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  chk_add_ovf_enable: assert property (@(posedge sys_clk) disable iff (reset)
    func_code == ffd_pkg::FC_ADD_KEEP_OVF |=> overflow_enable_q &&
      alu_ctrl_q == ffd_pkg::FG_ADD) // [RULE1]
    else $error("saved-overflow add lacks enable");
  chk_extend_gate: assert property (@(posedge sys_clk) disable iff (reset)
    extend_enable_q |-> overflow_enable_q && ($past(user_mem_ref) ||
      $past(special_code) == ffd_pkg::SP_SKIP_GROUP_TWO)) // [RULE2]
    else $error("extend enabled without overflow enable");
  chk_and_pattern: assert property (@(posedge sys_clk) disable iff (reset)
    func_code == ffd_pkg::FC_AND |=> alu_ctrl_q == ffd_pkg::FG_AND &&
      !a_load_q && !q_load_q) // [RULE3]
    else $error("AND pattern wrong");
  chk_ars_right: assert property (@(posedge sys_clk) disable iff (reset)
    func_code == ffd_pkg::FC_ARITH_SHIFT && right_one |=>
      t_bus_q[15] == t_bus_q[14] && a_load_q) // [RULE6]
    else $error("right arithmetic shift lost sign");
  chk_ars_left_ovf: assert property (@(posedge sys_clk) disable iff (reset)
    func_code == ffd_pkg::FC_ARITH_SHIFT && left_one &&
      (r_bus[14] ^ r_bus[15]) && s_bus == 16'h0000 |=>
      overflow_flipflop_q && q_next_q[0] == 1'b0) // [RULE7]
    else $error("left shift overflow not set");
  chk_clear_flag: assert property (@(posedge sys_clk) disable iff (reset)
    func_code == ffd_pkg::FC_CLEAR_FLAG && !flag_set |=>
      !cpu_flag_q && alu_ctrl_q == ffd_pkg::FG_IOR) // [RULE9]
    else $error("flag not cleared");
  chk_conditional_rom_jump_strobes: assert property (@(posedge sys_clk) disable iff (reset)
    is_conditional_rom_jump |=> seq_q.jump_field_flag && !seq_q.pc_read_low &&
      !seq_q.skip_field_decode_enable &&
      seq_q.rom_jump == $past(halt_or_irq) &&
      jump_target_q == $past(jump_bits)) // [RULE10] [RULE11] [RULE12]
    else $error("conditional jump strobes wrong");
  chk_set_ovf: assert property (@(posedge sys_clk) disable iff (reset)
    func_code == ffd_pkg::FC_SET_OVF |=> overflow_flipflop_q) // [RULE13]
    else $error("overflow code did not set flip-flop");
  chk_div_two_cycle: assert property (@(posedge sys_clk) disable iff (reset)
    is_div && div_state_q == FFD_DIV_TEST |=> freeze_q && !t_store_q &&
      !q_load_q ##1 !freeze_q) // [RULE19]
    else $error("divide step sequencing wrong");
  chk_dec_pattern: assert property (@(posedge sys_clk) disable iff (reset)
    func_code == ffd_pkg::FC_DECREMENT && s_bus == 16'h0000 |=>
      t_bus_q == $past(r_bus) - 16'h0001) // [RULE16]
    else $error("decrement result wrong");
endmodule

// [tb/ffd_regs_model.sv]
`timescale 1ns/10ps
// ----------------------------------------------
// A, Q and F registers standing behind the decoder
// ----------------------------------------------
module ffd_regs_model (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // Bench preset of the contents
  input wire logic preset,
  input wire logic [15:0] pre_a,
  input wire logic [15:0] pre_q,
  input wire logic [15:0] pre_f,
  // Decoder results
  input wire logic a_load_q,
  input wire logic [15:0] a_next_q,
  input wire logic q_load_q,
  input wire logic [15:0] q_next_q,
  input wire logic t_store_q,
  input wire logic [15:0] t_bus_q,
  // Register contents
  output logic [15:0] a_reg,
  output logic [15:0] q_reg,
  output logic [15:0] f_reg
);
  // F only takes the T-bus with a Q load, so a frozen cycle changes nothing
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      a_reg <= 16'h0000;
      q_reg <= 16'h0000;
      f_reg <= 16'h0000;
    end else if (preset) begin
      a_reg <= pre_a;
      q_reg <= pre_q;
      f_reg <= pre_f;
    end else begin
      if (a_load_q) a_reg <= a_next_q;
      if (q_load_q) q_reg <= q_next_q;
      if (q_load_q && t_store_q) f_reg <= t_bus_q;
    end
  end
endmodule

// [tb/tb.sv]
`timescale 1ns/10ps
module tb;
  typedef struct {int due; int k; logic [15:0] v;} ffd_note_t;
  localparam int K_ALU = 0, K_T = 1, K_OVE = 2, K_EXT = 3, K_OVF = 4;
  localparam int K_FLG = 5, K_FRZ = 6, K_TS = 7, K_SEQ = 8, K_JT = 9;
  localparam int K_AN = 10, K_QN = 11, K_AL = 12, K_QL = 13;
  // ----------------------------------------------
  // Stimulus, observed outputs and bookkeeping
  // ----------------------------------------------
  logic sys_clk, reset, user_mem_ref, halt_or_irq, ovf_clear, flag_set;
  logic [4:0] func_code, special_code;
  logic [7:0] jump_bits, jb, jump_target_q;
  logic [15:0] r_drv, r_bus, s_bus, a_reg, q_reg, f_reg, pre_a, pre_q, pre_f;
  logic [15:0] t_bus_q, a_next_q, q_next_q;
  logic preset, use_f, t_store_q, a_load_q, q_load_q, freeze_q, cpu_flag_q;
  logic overflow_enable_q, extend_enable_q, overflow_flipflop_q;
  ffd_pkg::ffd_alu_ctrl_t alu_ctrl_q;
  ffd_pkg::ffd_seq_t seq_q;
  ffd_note_t notes[$];
  integer seed = 88;
  int ncyc = 0, err_count = 0, n_tests = 0;
  string nm[14] = '{"alu_ctrl_q", "t_bus_q", "overflow_enable_q",
    "extend_enable_q", "overflow_flipflop_q", "cpu_flag_q", "freeze_q",
    "t_store_q", "seq_q", "jump_target_q", "a_next_q", "q_next_q",
    "a_load_q", "q_load_q"};

  // Upper word comes straight from F during the divide loop
  assign r_bus = use_f ? f_reg : r_drv;

  ffd_decoder uut (.sys_clk(sys_clk), .reset(reset), .func_code(func_code),
    .special_code(special_code), .jump_bits(jump_bits),
    .user_mem_ref(user_mem_ref), .halt_or_irq(halt_or_irq),
    .ovf_clear(ovf_clear), .flag_set(flag_set), .r_bus(r_bus),
    .s_bus(s_bus), .a_reg(a_reg), .q_reg(q_reg), .alu_ctrl_q(alu_ctrl_q),
    .t_bus_q(t_bus_q), .t_store_q(t_store_q), .a_load_q(a_load_q),
    .a_next_q(a_next_q), .q_load_q(q_load_q), .q_next_q(q_next_q),
    .overflow_enable_q(overflow_enable_q), .extend_enable_q(extend_enable_q),
    .overflow_flipflop_q(overflow_flipflop_q), .cpu_flag_q(cpu_flag_q),
    .freeze_q(freeze_q), .seq_q(seq_q), .jump_target_q(jump_target_q));

  ffd_regs_model regs (.sys_clk(sys_clk), .reset(reset), .preset(preset),
    .pre_a(pre_a), .pre_q(pre_q), .pre_f(pre_f), .a_load_q(a_load_q),
    .a_next_q(a_next_q), .q_load_q(q_load_q), .q_next_q(q_next_q),
    .t_store_q(t_store_q), .t_bus_q(t_bus_q), .a_reg(a_reg),
    .q_reg(q_reg), .f_reg(f_reg));

  // 40 MHz machine-cycle clock
  always #12.5 sys_clk = ~sys_clk;

  // ----------------------------------------------
  // Shared tasks
  // ----------------------------------------------
  function automatic logic [15:0] rnd();
    return 16'($random(seed));
  endfunction

  function automatic logic [15:0] obs(input int k);
    case (k)
      0: return 16'(alu_ctrl_q);
      1: return t_bus_q;
      2: return {15'h0000, overflow_enable_q};
      3: return {15'h0000, extend_enable_q};
      4: return {15'h0000, overflow_flipflop_q};
      5: return {15'h0000, cpu_flag_q};
      6: return {15'h0000, freeze_q};
      7: return {15'h0000, t_store_q};
      8: return 16'(seq_q);
      9: return {8'h00, jump_target_q};
      10: return a_next_q;
      11: return q_next_q;
      12: return {15'h0000, a_load_q};
      default: return {15'h0000, q_load_q};
    endcase
  endfunction

  task automatic check(input string name, input logic [15:0] seen,
                       input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Result of an edge's inputs shows one cycle later
  task automatic note(input int k, input logic [15:0] v);
    ffd_note_t n;
    n.due = ncyc + 2;
    n.k = k;
    n.v = v;
    notes.push_back(n);
  endtask

  task automatic op(input logic [4:0] code, input logic [4:0] sp,
                    input logic [15:0] r, input logic [15:0] s,
                    input logic [3:0] ctl);
    @(posedge sys_clk);
    jb = 8'($random(seed));
    func_code <= code;
    special_code <= sp;
    r_drv <= r;
    s_bus <= s;
    jump_bits <= jb;
    {user_mem_ref, halt_or_irq, ovf_clear, flag_set} <= ctl;
  endtask

  // Preset costs two idle cycles so A and Q are known at the next op
  task automatic setregs(input logic [15:0] a, q, f, input logic uf);
    op(5'h07, 5'h00, 16'h0000, 16'h0000, 4'h0);
    preset <= 1'h1;
    pre_a <= a;
    pre_q <= q;
    pre_f <= f;
    @(posedge sys_clk);
    preset <= 1'h0;
    use_f <= uf;
  endtask

  task automatic print_verdict();
    check("notes_left", 16'(notes.size()), 16'h0000);
    if (err_count == 0 && n_tests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // Oldest note is compared in the cycle its result is due
  always @(negedge sys_clk) begin
    ncyc++;
    while (notes.size() > 0 && notes[0].due <= ncyc) begin
      check(nm[notes[0].k], obs(notes[0].k), notes[0].v);
      void'(notes.pop_front());
    end
  end

  // Hang guard
  initial begin
    repeat (20000) @(posedge sys_clk);
    check("watchdog", 16'h0001, 16'h0000);
    print_verdict();
  end

  // ----------------------------------------------
  // Main sequence
  // ----------------------------------------------
  initial begin
    logic [15:0] a, b, q, f, d, v;
    logic [4:0] c;
    sys_clk = 1'h0;
    reset = 1'h1;
    {func_code, special_code, jump_bits, user_mem_ref, halt_or_irq} = '0;
    {ovf_clear, flag_set, r_drv, s_bus, preset, use_f} = '0;
    {pre_a, pre_q, pre_f} = '0;
    repeat (3) @(posedge sys_clk);
    check("seq_q", 16'(seq_q), 16'(ffd_pkg::SEQ_IDLE));
    reset <= 1'h0;
    // Logic AND with an overflow clear alongside
    a = rnd();
    b = rnd();
    op(ffd_pkg::FC_AND, 5'h00, a, b, 4'h2);
    note(K_ALU, 16'(ffd_pkg::FG_AND));
    note(K_T, a & b);
    note(K_OVE, 16'h0000);
    note(K_SEQ, 16'(ffd_pkg::SEQ_IDLE));
    note(K_OVF, 16'h0000);
    // Saved-overflow add: plain, overflowing, memory-reference with clear
    for (int i = 0; i < 3; i++) begin
      a = rnd() & 16'h3FFF;
      b = rnd() & 16'h3FFF;
      if (i == 1) {a[14], b[14]} = 2'h3;
      op(ffd_pkg::FC_ADD_KEEP_OVF,
         (i == 1) ? ffd_pkg::SP_SKIP_GROUP_TWO : 5'h00, a, b,
         (i == 2) ? 4'hA : 4'h0);
      note(K_ALU, 16'(ffd_pkg::FG_ADD));
      note(K_T, a + b);
      note(K_OVE, 16'h0001);
      note(K_EXT, {15'h0000, i != 0});
      note(K_OVF, {15'h0000, i == 1});
    end
    // Overflow set beats a clear and then holds
    op(ffd_pkg::FC_SET_OVF, 5'h00, 16'h0000, 16'h0000, 4'h2);
    note(K_ALU, 16'(ffd_pkg::FG_IOR));
    note(K_OVF, 16'h0001);
    op(5'h07, 5'h00, rnd(), rnd(), 4'h0);
    note(K_ALU, 16'(ffd_pkg::FG_PASS_R));
    note(K_OVF, 16'h0001);
    // CPU flag set, cleared, set against a clear, cleared again
    for (int j = 0; j < 4; j++) begin
      op((j == 0) ? 5'h07 : ffd_pkg::FC_CLEAR_FLAG, 5'h00, 16'h0000,
         16'h0000, {3'h0, ~j[0]});
      note(K_FLG, {15'h0000, ~j[0]});
      if (j != 0) note(K_ALU, 16'(ffd_pkg::FG_IOR));
    end
    // Decrement at zero and at a random word
    for (int j = 0; j < 2; j++) begin
      a = (j == 0) ? 16'h0000 : rnd();
      op(ffd_pkg::FC_DECREMENT, 5'h00, a, 16'h0000, 4'h0);
      note(K_ALU, 16'(ffd_pkg::FG_SUB_ONES));
      note(K_T, a - 16'h0001);
    end
    // Both jump codes, with and without halt or interrupt
    for (int j = 0; j < 4; j++) begin
      op(j[1] ? ffd_pkg::FC_COND_JUMP_ALT : ffd_pkg::FC_COND_JUMP, 5'h00,
         rnd(), rnd(), {1'h0, j[0], 2'h0});
      note(K_SEQ, {9'h000, 6'h20, j[0]});
      note(K_JT, {8'h00, jb});
      note(K_ALU, 16'(ffd_pkg::FG_IOR));
    end
    // Arithmetic shifts then rotates, right and left, clear held high
    for (int m = 0; m < 6; m++) begin
      a = rnd();
      q = rnd();
      b = rnd();
      b[15:14] = {m[1], 1'h1};
      c = (m < 4) ? ffd_pkg::FC_ARITH_SHIFT : ffd_pkg::FC_ROTATE;
      setregs(a, q, 16'h0000, 1'h0);
      op(c, m[0] ? ffd_pkg::SP_SHIFT_LEFT_ONE : ffd_pkg::SP_SHIFT_RIGHT_ONE,
         b, 16'h0000, 4'h2);
      note(K_ALU, 16'(ffd_pkg::FG_IOR));
      note(K_OVF, {15'h0000, m == 1});
      if (m[0] == 1'h0) begin
        note(K_T, {(m < 4) ? b[15] : a[0], b[15:1]});
        note(K_AN, {b[0], a[15:1]});
        note(K_AL, 16'h0001);
      end else begin
        note(K_T, (m < 4) ? {b[15], b[13:0], q[15]} :
          {b[14:0], q[15]});
        note(K_QN, {q[14:0], (m < 4) ? 1'h0 : b[15]});
        note(K_QL, 16'h0001);
      end
    end
    // Full divide, positive operands and F below the divisor
    v = rnd();
    d = {1'h0, v[14:0]} | 16'h0001;
    f = rnd() % d;
    q = rnd();
    setregs(16'h0000, q, f, 1'h1);
    for (int i = 0; i < 16; i++) begin
      op(ffd_pkg::FC_DIVIDE, ffd_pkg::SP_SHIFT_LEFT_ONE, 16'h0000, d,
         4'h0);
      note(K_FRZ, 16'h0001);
      note(K_TS, 16'h0000);
      note(K_QL, 16'h0000);
      op(ffd_pkg::FC_DIVIDE, ffd_pkg::SP_SHIFT_LEFT_ONE, 16'h0000, d,
         4'h0);
      note(K_FRZ, 16'h0000);
      note(K_TS, 16'h0001);
      b = f - d;
      if (f >= d) begin
        f = {b[14:0], q[15]};
        q = {q[14:0], 1'h1};
      end else begin
        f = {f[14:0], q[15]};
        q = {q[14:0], 1'h0};
      end
      note(K_T, f);
      note(K_QN, q);
      op(5'h07, 5'h00, 16'h0000, 16'h0000, 4'h0);
    end
    repeat (2) @(posedge sys_clk);
    check("f_reg", f_reg, f);
    check("q_reg", q_reg, q);
    repeat (3) @(posedge sys_clk);
    print_verdict();
  end
endmodule
